/* rtl/chi_pkg.sv */
// Constants and types for the counter hardware interrupt select block.
// Assumes a single 100 MHz system clock and an AXI4-Lite register master.
package chi_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [4:0] CHI_OFF_CTRL    = 5'h00;
  localparam logic [4:0] CHI_OFF_CMPVAL  = 5'h04;
  localparam logic [4:0] CHI_OFF_STATUS  = 5'h08;
  localparam logic [4:0] CHI_OFF_IRQ_EN  = 5'h0c;
  localparam logic [4:0] CHI_OFF_IRQ_PND = 5'h10;

  // Control register fields.
  localparam int CHI_CTRL_MODE_LSB = 0;
  localparam int CHI_CTRL_HWGATE   = 2;
  localparam int CHI_CTRL_CLRSTS   = 3;

  // Status register fields.
  localparam int CHI_COMPARE_HIT_FLAG  = 0;
  localparam int CHI_COUNT_OVERFLOW_FLAG = 1;
  localparam int CHI_COUNT_UNDERFLOW_FLAG = 2;
  localparam int CHI_STS_GATE = 3;

  // Interrupt source positions, shared by enable and pending registers.
  localparam int CHI_IRQ_NUM   = 5;
  localparam int CHI_IRQ_GOPEN = 0;
  localparam int CHI_IRQ_GCLOS = 1;
  localparam int CHI_IRQ_CMP   = 2;
  localparam int CHI_IRQ_OFLW  = 3;
  localparam int CHI_IRQ_UFLW  = 4;

  // Reset values.
  localparam logic [31:0] CHI_RST_CMPVAL = 32'h0000_0000;
  localparam logic [4:0]  CHI_RST_IRQ_EN = 5'h00;

  // AXI responses.
  localparam logic [1:0] CHI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CHI_RESP_SLVERR = 2'h2;

  // Only this channel owns the hardware gate.
  localparam int CHI_GATE_CHANNEL = 3;

  // Output characteristic of the comparator.
  typedef enum logic [1:0] {
    CHI_CMP_NONE  = 2'h0,
    CHI_CMP_GE    = 2'h1,
    CHI_CMP_LE    = 2'h3,
    CHI_CMP_PULSE = 2'h2
  } chi_cmp_mode_t;

  // Whole state of the block, registered in one process.
  typedef struct packed {
    logic                   gate_s1;
    logic                   gate_s2;
    logic                   gate_d;
    chi_cmp_mode_t          cmp_mode;
    logic                   external_count_gate_en;
    logic [31:0]            cmp_val;
    logic [31:0]            cnt_d;
    logic                   cmp_cond_d;
    logic                   cmp_flag;
    logic                   ovf_flag;
    logic                   udf_flag;
    logic [CHI_IRQ_NUM-1:0] irq_en;
    logic [CHI_IRQ_NUM-1:0] irq_pend;
    logic                   irq;
    logic                   awready;
    logic                   wready;
    logic                   aw_got;
    logic                   w_got;
    logic [4:0]             aw_addr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } chi_state_t;

endpackage

/* rtl/chi_irq_select.sv */
// Counter hardware interrupt select: five enabled event sources, sticky
// overflow/underflow flags, a live compare flag and an AXI4-Lite register slave.
// Assumes count value and overflow/underflow pulses come from counter logic
// on sys_clk; the gate input is an asynchronous pin.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1: Gate rising edge requests interrupt when enabled.
// RULE2: Gate falling edge requests interrupt when enabled.
// RULE3: Comparator trigger requests interrupt when enabled.
// RULE4: Overflow requests interrupt when enabled.
// RULE5: Underflow requests interrupt when enabled.
// RULE6: Comparator follows chosen output characteristic.
// RULE7: Overflow/underflow flags stick until status clear.
// RULE8: Gate events exist only on channel three.
// RULE9: One request per event; enables reset off.
module chi_irq_select #(
  parameter int CHANNEL = 3
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    external_count_gate,
  input  wire logic [31:0]             count_value,
  input  wire logic                    count_overflow_evt,
  input  wire logic                    count_underflow_evt,
  output var  logic                    irq,
  output var  logic                    compare_hit_flag,
  output var  logic                    count_overflow_flag,
  output var  logic                    count_underflow_flag,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [31:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import chi_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Merge a write word into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True for the word offsets that exist.
  function automatic logic mapped(input logic [4:0] a);
    return (a == CHI_OFF_CTRL) || (a == CHI_OFF_CMPVAL) || (a == CHI_OFF_STATUS) ||
           (a == CHI_OFF_IRQ_EN) || (a == CHI_OFF_IRQ_PND);
  endfunction

  localparam logic HAS_GATE = (CHANNEL == CHI_GATE_CHANNEL);

  chi_state_t st_r;
  chi_state_t st_nxt;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Event detection, flags, interrupt bookkeeping and the bus slave.
  always_comb begin
    logic              gate_rise;
    logic              gate_fall;
    logic              cmp_cond;
    logic              cmp_evt;
    logic              clr_sts;
    logic              do_wr;
    logic [31:0]       wval;
    logic [CHI_IRQ_NUM-1:0] evt;
    logic [CHI_IRQ_NUM-1:0] w1c;
    gate_rise = 1'b0;
    gate_fall = 1'b0;
    cmp_cond  = 1'b0;
    cmp_evt   = 1'b0;
    clr_sts   = 1'b0;
    do_wr     = 1'b0;
    wval      = 32'h0000_0000;
    evt       = '0;
    w1c       = '0;
    st_nxt    = st_r;

    // Two-stage synchroniser; only the second stage feeds the edge logic.
    st_nxt.gate_s1 = external_count_gate;
    st_nxt.gate_s2 = st_r.gate_s1;
    st_nxt.gate_d  = st_r.gate_s2;
    // The gate is ignored unless this is the gate channel and it is enabled.
    if (HAS_GATE && st_r.external_count_gate_en) begin // RULE8
      gate_rise = st_r.gate_s2 && !st_r.gate_d; // RULE1
      gate_fall = !st_r.gate_s2 && st_r.gate_d; // RULE2
    end

    // Comparator; edges of the condition make the trigger, so a level that
    // stays true does not raise a stream of requests.
    st_nxt.cnt_d = count_value;
    unique case (st_r.cmp_mode)
      CHI_CMP_NONE:  cmp_cond = 1'b0; // RULE6
      CHI_CMP_GE:    cmp_cond = count_value >= st_r.cmp_val; // RULE6
      CHI_CMP_LE:    cmp_cond = count_value <= st_r.cmp_val; // RULE6
      CHI_CMP_PULSE: cmp_cond = (count_value == st_r.cmp_val) &&
                                (st_r.cnt_d != count_value); // RULE6
    endcase
    st_nxt.cmp_cond_d = cmp_cond;
    st_nxt.cmp_flag   = cmp_cond;
    cmp_evt = cmp_cond && !st_r.cmp_cond_d;

    evt[CHI_IRQ_GOPEN] = gate_rise;
    evt[CHI_IRQ_GCLOS] = gate_fall;
    evt[CHI_IRQ_CMP]   = cmp_evt; // RULE3
    evt[CHI_IRQ_OFLW]  = count_overflow_evt; // RULE4
    evt[CHI_IRQ_UFLW]  = count_underflow_evt; // RULE5

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      do_wr         = 1'b1;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.aw_addr) ? CHI_RESP_OKAY : CHI_RESP_SLVERR;
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

    // Register writes.
    if (do_wr) begin
      unique case (st_r.aw_addr)
        CHI_OFF_CTRL: begin
          wval = merge({28'h0000000, 1'b0, st_r.external_count_gate_en, st_r.cmp_mode},
                       st_r.wdata, st_r.wstrb);
          st_nxt.cmp_mode   = chi_cmp_mode_t'(wval[CHI_CTRL_MODE_LSB +: 2]);
          st_nxt.external_count_gate_en = wval[CHI_CTRL_HWGATE];
          clr_sts           = wval[CHI_CTRL_CLRSTS];
        end
        CHI_OFF_CMPVAL: st_nxt.cmp_val = merge(st_r.cmp_val, st_r.wdata, st_r.wstrb);
        CHI_OFF_IRQ_EN: begin
          wval = merge({27'h0000000, st_r.irq_en}, st_r.wdata, st_r.wstrb);
          st_nxt.irq_en = wval[CHI_IRQ_NUM-1:0];
        end
        CHI_OFF_IRQ_PND: begin
          if (st_r.wstrb[0]) begin
            w1c = st_r.wdata[CHI_IRQ_NUM-1:0];
          end
        end
        default: wval = 32'h0000_0000;
      endcase
    end

    // Sticky limit flags; an event in the clearing cycle wins.
    st_nxt.ovf_flag = (st_r.ovf_flag && !clr_sts) || count_overflow_evt; // RULE7
    st_nxt.udf_flag = (st_r.udf_flag && !clr_sts) || count_underflow_evt; // RULE7

    // A disabled source never pends; a pending bit holds one request until
    // software writes one to it, and a new event beats that write.
    st_nxt.irq_pend = (st_r.irq_pend & ~w1c) | (evt & st_r.irq_en); // RULE9
    st_nxt.irq      = |st_nxt.irq_pend;

    // Read channel.
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = mapped(s_axi_araddr[4:0]) ? CHI_RESP_OKAY : CHI_RESP_SLVERR;
      st_nxt.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr[4:0])
        CHI_OFF_CTRL:    st_nxt.rdata = {29'h0000000, st_r.external_count_gate_en, st_r.cmp_mode};
        CHI_OFF_CMPVAL:  st_nxt.rdata = st_r.cmp_val;
        CHI_OFF_STATUS:  st_nxt.rdata = {28'h0000000, st_r.gate_s2, st_r.udf_flag,
                                         st_r.ovf_flag, st_r.cmp_flag};
        CHI_OFF_IRQ_EN:  st_nxt.rdata = {27'h0000000, st_r.irq_en};
        CHI_OFF_IRQ_PND: st_nxt.rdata = {27'h0000000, st_r.irq_pend};
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // All enables come up off, so nothing interrupts before configuration.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.cmp_mode <= CHI_CMP_NONE;
      st_r.cmp_val  <= CHI_RST_CMPVAL;
      st_r.irq_en   <= CHI_RST_IRQ_EN; // RULE9
      st_r.awready  <= 1'b1;
      st_r.wready   <= 1'b1;
      st_r.arready  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flip-flops.
  assign irq                  = st_r.irq;
  assign compare_hit_flag     = st_r.cmp_flag;
  assign count_overflow_flag  = st_r.ovf_flag;
  assign count_underflow_flag = st_r.udf_flag;
  assign s_axi_awready        = st_r.awready;
  assign s_axi_wready         = st_r.wready;
  assign s_axi_bvalid         = st_r.bvalid;
  assign s_axi_bresp          = st_r.bresp;
  assign s_axi_arready        = st_r.arready;
  assign s_axi_rvalid         = st_r.rvalid;
  assign s_axi_rdata          = st_r.rdata;
  assign s_axi_rresp          = st_r.rresp;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // Helper for the sticky check: a control write carrying the clear bit.
  logic do_clr_chk;
  assign do_clr_chk = st_r.aw_got && st_r.w_got && !st_r.bvalid &&
                      (st_r.aw_addr == CHI_OFF_CTRL) && st_r.wstrb[0] &&
                      st_r.wdata[CHI_CTRL_CLRSTS];

  AST_GATE_OPEN: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE1
    (st_r.gate_s2 && !st_r.gate_d && st_r.external_count_gate_en && HAS_GATE &&
     st_r.irq_en[CHI_IRQ_GOPEN]) |=> st_r.irq_pend[CHI_IRQ_GOPEN] && irq)
    else $error("Gate opening did not pend an interrupt.");

  AST_GATE_CLOSE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE2
    (!st_r.gate_s2 && st_r.gate_d && st_r.external_count_gate_en && HAS_GATE &&
     st_r.irq_en[CHI_IRQ_GCLOS]) |=> st_r.irq_pend[CHI_IRQ_GCLOS])
    else $error("Gate closing did not pend an interrupt.");

  AST_CMP_EVT: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
    ($rose(st_r.cmp_flag) && $past(st_r.irq_en[CHI_IRQ_CMP])) |-> st_r.irq_pend[CHI_IRQ_CMP])
    else $error("Comparator trigger did not pend an interrupt.");

  AST_OFLW: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE4
    (count_overflow_evt && st_r.irq_en[CHI_IRQ_OFLW]) |=> irq)
    else $error("Overflow interrupt missing.");

  AST_UFLW: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE5
    (count_underflow_evt && st_r.irq_en[CHI_IRQ_UFLW]) |=> st_r.irq_pend[CHI_IRQ_UFLW])
    else $error("Underflow interrupt missing.");

  AST_CMP_NONE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE6
    (st_r.cmp_mode == CHI_CMP_NONE) [*2] |-> !compare_hit_flag)
    else $error("Compare flag set with no comparison.");

  AST_FLAG_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE7
    (count_overflow_flag && !(do_clr_chk)) |=> count_overflow_flag)
    else $error("Overflow flag dropped without a status clear.");

  AST_NO_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE8
    !(HAS_GATE && st_r.external_count_gate_en) |=> !$rose(st_r.irq_pend[CHI_IRQ_GOPEN]))
    else $error("Gate interrupt without a hardware gate.");

  AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE9
    (!st_r.irq_en[CHI_IRQ_OFLW] && !st_r.irq_pend[CHI_IRQ_OFLW]) |=>
      !st_r.irq_pend[CHI_IRQ_OFLW])
    else $error("Disabled source raised a request.");

endmodule

`default_nettype wire

/* dv/chi_irq_host.sv */
// Controller-side receiver of the hardware interrupt line.
// Assumes the level irq output of the select block on the same clock.
`timescale 1ns/100ps
`default_nettype none
module chi_irq_host (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       irq,
  output var  logic [7:0] irq_count
);
  // ---------------------------------------------------------------------
  // Request counter
  // ---------------------------------------------------------------------
  logic irq_d;

  // Each rising level is one request; a held level must not count twice.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_d     <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      irq_d <= irq;
      if (irq && !irq_d) begin
        irq_count <= irq_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the interrupt select block.
// Assumes chi_pkg, chi_irq_select and chi_irq_host are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import chi_pkg::*;
  // ---------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        gate    = 1'b0;
  logic [31:0] cnt     = 32'h0;
  logic        ovf     = 1'b0;
  logic        udf     = 1'b0;
  logic [31:0] awaddr  = 32'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [31:0] araddr  = 32'h0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        irq, hit, oflag, uflag, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, last_resp;
  logic [31:0] rdata, rd;
  logic [7:0]  host_cnt;
  int          n_errors = 0;
  int          num_checks = 0;

  always #5 sys_clk = ~sys_clk;

  chi_irq_select #(.CHANNEL(3)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .external_count_gate(gate), .count_value(cnt), .count_overflow_evt(ovf),
    .count_underflow_evt(udf), .irq(irq), .compare_hit_flag(hit),
    .count_overflow_flag(oflag), .count_underflow_flag(uflag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  chi_irq_host host (.sys_clk(sys_clk), .reset_n(reset_n), .irq(irq),
    .irq_count(host_cnt));

  // ---------------------------------------------------------------------
  // Compare, bus, counter-event and verdict tasks
  // ---------------------------------------------------------------------
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string m);
    chkw({31'h0, got}, {31'h0, exp}, m);
  endtask

  // Write: address and data offered together, each released once taken.
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr  <= {27'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    last_resp = bresp;
    bready <= 1'b0;
    chkb(bvalid, 1'b1, "write answer");
  endtask

  task automatic axr(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr  <= {27'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rd = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    chkb(rvalid, 1'b1, "read answer");
  endtask

  // One-cycle counter event; u selects underflow instead of overflow.
  task automatic ev(input bit u);
    @(posedge sys_clk);
    if (u) udf <= 1'b1;
    else ovf <= 1'b1;
    @(posedge sys_clk);
    ovf <= 1'b0;
    udf <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    axr(CHI_OFF_IRQ_EN);
    chkw(rd, 32'h0, "enables after reset");
    chkb(irq, 1'b0, "irq after reset");
    $display("test reset done");
  endtask

  task automatic t_ovf_udf();
    axw(CHI_OFF_IRQ_EN, 32'h08);
    ev(1'b0);
    chkb(irq, 1'b1, "overflow irq");
    axw(CHI_OFF_IRQ_PND, 32'h08);
    repeat (2) @(posedge sys_clk);
    chkb(irq, 1'b0, "irq after pending clear");
    chkb(oflag, 1'b1, "overflow flag sticky");
    ev(1'b1);
    chkb(uflag, 1'b1, "underflow flag");
    axr(CHI_OFF_STATUS);
    chkw(rd, 32'h0000_0006, "status word with both limit flags");
    axr(CHI_OFF_IRQ_PND);
    chkw(rd, 32'h0, "disabled underflow");
    axw(CHI_OFF_IRQ_EN, 32'h10);
    ev(1'b1);
    axr(CHI_OFF_IRQ_PND);
    chkw(rd, 32'h10, "enabled underflow");
    axw(CHI_OFF_IRQ_PND, 32'h10);
    axw(CHI_OFF_CTRL, 32'h08);
    repeat (2) @(posedge sys_clk);
    chkb(oflag | uflag, 1'b0, "flags cleared");
    $display("test overflow underflow done");
  endtask

  // Modes none, at-or-above, at-or-below and pulse, each crossing 100.
  task automatic t_cmp();
    logic [1:0]  md [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [31:0] fr [4] = '{32'd50, 32'd50, 32'd150, 32'd99};
    logic [31:0] to [4] = '{32'd150, 32'd150, 32'd100, 32'd100};
    axw(CHI_OFF_CMPVAL, 32'd100);
    chkw({30'h0, last_resp}, {30'h0, CHI_RESP_OKAY}, "mapped write response");
    axr(CHI_OFF_CMPVAL);
    chkw(rd, 32'd100, "compare value readback");
    axw(CHI_OFF_IRQ_EN, 32'h04);
    for (int i = 0; i < 4; i++) begin
      cnt <= fr[i];
      axw(CHI_OFF_CTRL, {30'h0, md[i]});
      axw(CHI_OFF_IRQ_PND, 32'h04);
      cnt <= to[i];
      repeat (3) @(posedge sys_clk);
      if (i == 0) chkb(hit, 1'b0, "no comparison hit");
      if (i == 1) chkb(hit, 1'b1, "comparison hit at or above");
      axr(CHI_OFF_IRQ_PND);
      chkw(rd, (i == 0) ? 32'h0 : 32'h04, "comparator pending");
    end
    axw(CHI_OFF_IRQ_PND, 32'h04);
    $display("test comparator done");
  endtask

  task automatic t_gate();
    axw(CHI_OFF_IRQ_EN, 32'h03);
    axw(CHI_OFF_CTRL, 32'h00);
    gate <= 1'b1;
    repeat (6) @(posedge sys_clk);
    axr(CHI_OFF_IRQ_PND);
    chkw(rd, 32'h0, "gate edge without gate control");
    gate <= 1'b0;
    axw(CHI_OFF_CTRL, 32'h04);
    gate <= 1'b1;
    repeat (6) @(posedge sys_clk);
    axr(CHI_OFF_IRQ_PND);
    chkw(rd, 32'h01, "gate opening");
    axw(CHI_OFF_IRQ_PND, 32'h01);
    gate <= 1'b0;
    repeat (6) @(posedge sys_clk);
    axr(CHI_OFF_IRQ_PND);
    chkw(rd, 32'h02, "gate closing");
    axw(CHI_OFF_IRQ_PND, 32'h02);
    axr(5'h14);
    chkw({30'h0, last_resp}, {30'h0, CHI_RESP_SLVERR}, "unmapped read");
    axw(5'h14, 32'h0000_0000);
    chkw({30'h0, last_resp}, {30'h0, CHI_RESP_SLVERR}, "unmapped write");
    $display("test gate done");
  endtask

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_ovf_udf();
    t_cmp();
    t_gate();
    repeat (3) @(posedge sys_clk);
    chkw({24'h0, host_cnt}, 32'd7, "one request per event");
    results();
  end

  // The tests take a few hundred cycles; this span is far beyond that.
  initial begin
    #200us;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
